// [verilog/empc_pkg.sv]
// Constants and types for the emulation mode pin control block.
// Assumes a single core clock domain; no register bus.
package empc_pkg;

  // Strap decode
  typedef enum logic [1:0] {
    EMPC_MODE_NORMAL  = 2'b00,
    EMPC_MODE_ADAPTER = 2'b01,
    EMPC_MODE_PROBE   = 2'b10,
    EMPC_MODE_TEST    = 2'b11
  } empc_mode_type;

  // Reset one-shot stretch in ns, rounded up to cycles of the core clock
  localparam int unsigned EMPC_ONESHOT_NS     = 64;
  localparam int unsigned EMPC_CLK_PERIOD_NS  = 8;
  localparam int unsigned EMPC_ONESHOT_CYC    =
    (EMPC_ONESHOT_NS + EMPC_CLK_PERIOD_NS - 1) / EMPC_CLK_PERIOD_NS;

  // Count at which straps are taken: three sync stages plus the filter
  localparam int unsigned EMPC_CAPTURE_CYC    = 4;

  // Values after reset
  localparam logic        EMPC_RST_SER_DIV2   = 1'b0;
  localparam logic        EMPC_RST_ASYNC_TX_CH0_TRI   = 1'b0;
  localparam logic [1:0]  EMPC_RST_MODE       = 2'b00;
  // Status word: internal and peripheral resets held, all enables off
  localparam logic [16:0] EMPC_RST_STATUS     = 17'h18000;

  // Pin group bit positions within the direction/enable vector
  localparam int unsigned EMPC_PG_CLK   = 0;
  localparam int unsigned EMPC_PG_M1    = 1;
  localparam int unsigned EMPC_PG_MEM_REQUEST_N  = 2;
  localparam int unsigned EMPC_PG_IO_REQUEST_N  = 3;
  localparam int unsigned EMPC_PG_RD    = 4;
  localparam int unsigned EMPC_PG_WR    = 5;
  localparam int unsigned EMPC_PG_REFRESH_CYCLE_N  = 6;
  localparam int unsigned EMPC_PG_HALT  = 7;
  localparam int unsigned EMPC_PG_ST    = 8;
  localparam int unsigned EMPC_PG_BGNT  = 9;
  localparam int unsigned EMPC_PG_ADDR  = 10;
  localparam int unsigned EMPC_PG_NUM   = 11;

endpackage

// [verilog/empc_sync_if.sv]
// Carrier between the top and its strap synchroniser.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface empc_sync_if;
  logic [1:0] raw;
  logic [1:0] stable;
  modport sync (input raw, output stable);
  modport user (output raw, input stable);
endinterface

// [verilog/empc_sync3.sv]
// Three-stage synchroniser with agreement filter for pin levels.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module empc_sync3
  import empc_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  input  wire logic  ce_i,
  // Data
  empc_sync_if.sync  sif
);

  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [WIDTH-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_out;

  // Stage one is read only by stage two; the filter uses stages two and three
  always_comb begin
    nxt_s1  = s1_ff;
    nxt_s2  = s2_ff;
    nxt_s3  = s3_ff;
    nxt_out = out_ff;
    if (ce_i) begin
      nxt_s1 = sif.raw;
      nxt_s2 = s1_ff;
      nxt_s3 = s2_ff;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          nxt_out[i] = s3_ff[i];
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end else begin
      s1_ff  <= nxt_s1;
      s2_ff  <= nxt_s2;
      s3_ff  <= nxt_s3;
      out_ff <= nxt_out;
    end
  end

  assign sif.stable = out_ff;

endmodule

// [verilog/empc_top.sv]
// Emulation mode pin control: mode decode, pin direction, power-down
// pin states, reset one-shot, oscillator disable, serial clock divider.
// Assumes the core reports sleep/halt and the pin mux selections as
// levels on the core clock; pad cells combine the enables.
// Function
// - decode straps: normal, adapter, probe, test
// - adapter: core signals off, peripherals keep running
// - adapter: core bus pins inputs, wait/ext_irq_zero_n outputs
// - adapter: no edge detect on irq one/two
// - probe mode: every output high impedance except the sleep/halt strobe and select force-high
// - reset clears configuration, boundaries, serial, ports
// - normal: one-shot stretches reset; adapter bypasses
// - oscillator off in adapter and probe modes
// - sleep/halt: selected memory strobes driven high
// - sleep/halt: rom and ram selects high
// - sleep/halt: read, write float; io select floats when selected
// - power-down: address and data float
// - host port emulation off in power-down
// - serial clock undivided after reset
// - async tx0 halt float only when enabled
`timescale 1ns/1ps
module empc_top
  import empc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Mode straps (pins)
  input  wire logic              mode_strap_low_i,
  input  wire logic              mode_strap_high_i,
  // Core state and configuration
  input  wire logic              core_power_down_i,
  input  wire logic              mrd_selected_i,
  input  wire logic              mwr_selected_i,
  input  wire logic              io_select_n_selected_i,
  input  wire logic              a18_selected_i,
  input  wire logic              ser_div2_wr_i,
  input  wire logic              ser_div2_val_i,
  input  wire logic              async_tx_ch0_tri_wr_i,
  input  wire logic              async_tx_ch0_tri_val_i,
  input  wire logic              irq12_edge_req_i,
  // Mode status
  output logic [1:0]             mode_o,
  output logic                   osc_disable_o,
  output logic                   int_reset_o,
  output logic                   periph_reset_o,
  output logic                   ser_clk_div2_o,
  output logic                   host_emul_en_o,
  output logic                   irq12_edge_en_o,
  // Core bus pin output enables, high while driving
  output logic [EMPC_PG_NUM-1:0] core_pin_oe_o,
  output logic                   wait_oe_o,
  output logic                   irq_zero_od_en_o,
  output logic                   data_oe_allow_o,
  output logic                   eclk_oe_o,
  output logic                   async_tx_ch0_oe_o,
  output logic                   async_tx_ch1_oe_o,
  output logic                   rts_ch0_oe_o,
  // Power-down forced states
  output logic                   mem_strobe_force_hi_o,
  output logic                   sel_force_hi_o,
  output logic                   io_select_oe_o,
  output logic                   rdwr_oe_o,
  output logic                   addr_oe_o,
  output logic                   a18_oe_o,
  output logic                   periph_out_oe_o
);

  empc_sync_if sif ();

  logic [1:0]             mode_ff, nxt_mode;
  logic                   cap_ff, nxt_cap;
  logic [7:0]             shot_ff, nxt_shot;
  logic                   div2_ff, nxt_div2;
  logic                   txtri_ff, nxt_txtri;
  logic                   pd_ff, nxt_pd;
  logic [EMPC_PG_NUM-1:0] oe_ff, nxt_oe;
  logic [16:0]            st_ff, nxt_st;

  // Straps are pins from outside the clock domain
  assign sif.raw = {mode_strap_high_i, mode_strap_low_i};

  empc_sync3 #(
    .WIDTH (2)
  ) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .sif    (sif)
  );

  function automatic logic is_mode(input logic [1:0] m,
                                   input empc_mode_type t);
    is_mode = (m == t);
  endfunction

  // Strap capture, one-shot, control bits
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_cap   = cap_ff;
    nxt_shot  = shot_ff;
    nxt_div2  = div2_ff;
    nxt_txtri = txtri_ff;
    nxt_pd    = core_power_down_i;
    if (!cap_ff) begin
      // Straps settle through three stages before they are trusted
      nxt_shot = shot_ff + 8'h01;
      if (shot_ff == 8'(EMPC_CAPTURE_CYC)) begin
        nxt_mode = sif.stable;
        nxt_cap  = 1'b1;
        nxt_shot = 8'h00;
      end
    end else if (is_mode(mode_ff, EMPC_MODE_NORMAL) &&
                 shot_ff < 8'(EMPC_ONESHOT_CYC)) begin
      nxt_shot = shot_ff + 8'h01;     // stretch internal reset
    end
    if (ser_div2_wr_i) begin
      nxt_div2 = ser_div2_val_i;
    end
    if (async_tx_ch0_tri_wr_i) begin
      nxt_txtri = async_tx_ch0_tri_val_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_ff  <= EMPC_RST_MODE;
      cap_ff   <= 1'b0;
      shot_ff  <= 8'h00;
      div2_ff  <= EMPC_RST_SER_DIV2;  // undivided after reset
      txtri_ff <= EMPC_RST_ASYNC_TX_CH0_TRI;
      pd_ff    <= 1'b0;
    end else if (ce_i) begin
      mode_ff  <= nxt_mode;
      cap_ff   <= nxt_cap;
      shot_ff  <= nxt_shot;
      div2_ff  <= nxt_div2;
      txtri_ff <= nxt_txtri;
      pd_ff    <= nxt_pd;
    end
  end

  // Pin enable decode; test mode treated like probe as a safe choice
  always_comb begin
    logic norm;
    logic adpt;
    logic prb;
    norm = cap_ff && is_mode(mode_ff, EMPC_MODE_NORMAL);
    adpt = cap_ff && is_mode(mode_ff, EMPC_MODE_ADAPTER);
    prb  = !norm && !adpt;
    nxt_oe = {EMPC_PG_NUM{norm}};
    if (pd_ff) begin
      nxt_oe[EMPC_PG_RD]   = 1'b0;
      nxt_oe[EMPC_PG_WR]   = 1'b0;
      nxt_oe[EMPC_PG_ADDR] = 1'b0;
    end
    nxt_st = '0;
    // Oscillator stays on until the straps are known; a part strapped
    // normal may be clocked from it
    nxt_st[0]  = cap_ff && !norm;                // osc off
    nxt_st[1]  = adpt;                           // wait out
    nxt_st[2]  = adpt;                           // ext_irq_zero_n od
    nxt_st[3]  = !prb && !pd_ff;                 // data
    nxt_st[4]  = norm;                           // E clk
    nxt_st[5]  = norm && !(txtri_ff && pd_ff);
    nxt_st[6]  = norm;                           // tx1
    nxt_st[7]  = norm;                           // request_to_send_ch0
    nxt_st[8]  = pd_ff && (mrd_selected_i || mwr_selected_i);
    nxt_st[9]  = pd_ff;
    nxt_st[10] = !prb && !(pd_ff && io_select_n_selected_i);
    nxt_st[11] = norm && !pd_ff && a18_selected_i;
    nxt_st[12] = !prb;                           // peripherals
    nxt_st[13] = !prb && !pd_ff;                 // host port
    nxt_st[14] = norm && irq12_edge_req_i;
    nxt_st[15] = !(adpt || (norm && shot_ff >= 8'(EMPC_ONESHOT_CYC)));
    nxt_st[16] = !cap_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      oe_ff    <= '0;
      st_ff    <= EMPC_RST_STATUS; // both resets held
    end else if (ce_i) begin
      oe_ff    <= nxt_oe;
      st_ff    <= nxt_st;
    end
  end

  // Outputs come straight from flip-flops
  assign mode_o                = mode_ff;
  assign osc_disable_o         = st_ff[0];
  assign wait_oe_o             = st_ff[1];
  assign irq_zero_od_en_o      = st_ff[2];
  assign data_oe_allow_o       = st_ff[3];
  assign eclk_oe_o             = st_ff[4];
  assign async_tx_ch0_oe_o     = st_ff[5];
  assign async_tx_ch1_oe_o     = st_ff[6];
  assign rts_ch0_oe_o          = st_ff[7];
  assign mem_strobe_force_hi_o = st_ff[8];
  assign sel_force_hi_o        = st_ff[9];
  assign io_select_oe_o        = st_ff[10];
  assign a18_oe_o              = st_ff[11];
  assign periph_out_oe_o       = st_ff[12];
  assign host_emul_en_o        = st_ff[13];
  assign irq12_edge_en_o       = st_ff[14];
  assign int_reset_o           = st_ff[15];
  assign periph_reset_o        = st_ff[16];
  assign ser_clk_div2_o        = div2_ff;
  assign core_pin_oe_o         = oe_ff;
  assign rdwr_oe_o             = oe_ff[EMPC_PG_RD];
  assign addr_oe_o             = oe_ff[EMPC_PG_ADDR];

  // Assertions
  a_probe_all_off: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && cap_ff && is_mode(mode_ff, EMPC_MODE_PROBE)) |=>
      (oe_ff == '0 && !st_ff[4] && !data_oe_allow_o &&
       !periph_out_oe_o && !io_select_oe_o && !a18_oe_o))
    else $error("probe mode left an output enabled");
  a_adapter_osc_off: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && cap_ff && !is_mode(mode_ff, EMPC_MODE_NORMAL)) |=>
      osc_disable_o)
    else $error("oscillator running outside normal mode");
  a_adapter_core_in: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && cap_ff && is_mode(mode_ff, EMPC_MODE_ADAPTER)) |=>
      (core_pin_oe_o == '0 && wait_oe_o && irq_zero_od_en_o))
    else $error("adapter pin directions wrong");
  a_adapter_tx_off: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && is_mode(mode_ff, EMPC_MODE_ADAPTER)) |=>
      (!async_tx_ch0_oe_o && !async_tx_ch1_oe_o && !rts_ch0_oe_o &&
       !eclk_oe_o))
    else $error("adapter left transmit driving");
  a_edge_off: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && is_mode(mode_ff, EMPC_MODE_ADAPTER)) |=> !irq12_edge_en_o)
    else $error("edge detect enabled in adapter mode");
  a_pd_sel_high: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && core_power_down_i) ##1 ce_i |=>
      (sel_force_hi_o && !addr_oe_o && !rdwr_oe_o && !host_emul_en_o))
    else $error("power-down pin states wrong");
  a_div_reset: assert property (
    @(posedge mclk_i) rst_i |=> !ser_clk_div2_o)
    else $error("serial divider not undivided after reset");
  a_tx0_tri: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && !txtri_ff && is_mode(mode_ff, EMPC_MODE_NORMAL) && cap_ff)
      |=> async_tx_ch0_oe_o)
    else $error("tx0 floated without enable");
  a_mode_hold: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    cap_ff |=> $stable(mode_ff))
    else $error("captured mode changed");

  c_normal: cover property (@(posedge mclk_i)
    cap_ff && mode_ff == EMPC_MODE_NORMAL && !int_reset_o);
  c_adapter: cover property (@(posedge mclk_i)
    cap_ff && mode_ff == EMPC_MODE_ADAPTER);
  c_probe: cover property (@(posedge mclk_i)
    cap_ff && mode_ff == EMPC_MODE_PROBE);
  c_pd: cover property (@(posedge mclk_i) sel_force_hi_o && mode_ff == 2'h0);

endmodule

// [verification/empc_emu_model.sv]
// Emulator-side model: drives the mode straps for the mode the bench picks.
// Assumes the bench only changes the mode around reset, or on purpose.
`timescale 1ns/1ps
module empc_emu_model
  import empc_pkg::*;
(
  // Mode wanted by the bench
  input  wire logic [1:0] mode_sel_i,
  // Strap pins
  output logic            mode_strap_low_o,
  output logic            mode_strap_high_o,
  // High while the emulator drives request and address eighteen pins
  output logic            emu_bus_drive_o
);
  empc_mode_type strap;

  // Reserved code never reaches the pins; falls back to normal
  always_comb begin
    if (mode_sel_i == EMPC_MODE_TEST) begin
      strap = EMPC_MODE_NORMAL;
    end else begin
      strap = empc_mode_type'(mode_sel_i);
    end
  end

  // Plain static levels while the mode is held
  assign mode_strap_low_o  = strap[0];
  assign mode_strap_high_o = strap[1];

  // In adapter mode the emulator owns the shared request and A18 pins
  assign emu_bus_drive_o   = (strap == EMPC_MODE_ADAPTER);
endmodule

// [verification/empc_top_test.sv]
// Self-checking bench for the emulation mode pin control block.
// Assumes a single core clock; the emulator model drives the straps.
`timescale 1ns/1ps
module empc_top_test
  import empc_pkg::*;
;
  logic mclk_i, rst_i, ce_i, strap_lo, strap_hi, pd, mrd_s, mwr_s, ios_s;
  logic a18_s, dv_wr, dv_val, tx_wr, tx_val, edge_req;
  logic [1:0] mode_sel, mode_o;
  logic osc_o, irst_o, prst_o, div2_o, host_o, edge_o, wait_o, irq0_o;
  logic data_o, eclk_o, tx0_o, tx1_o, rts_o, mstr_o, sel_o, ios_o, rdwr_o;
  logic addr_o, a18_o, per_o, emu_drv;
  logic [EMPC_PG_NUM-1:0] core_o;
  logic [19:0] pv, pe;
  int n_fail = 0;
  int comparisons = 0;
  int gap;

  empc_emu_model empc_emu_model_i (.mode_sel_i(mode_sel),
    .mode_strap_low_o(strap_lo), .mode_strap_high_o(strap_hi),
    .emu_bus_drive_o(emu_drv));
  empc_top empc_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .mode_strap_low_i(strap_lo), .mode_strap_high_i(strap_hi),
    .core_power_down_i(pd), .mrd_selected_i(mrd_s), .mwr_selected_i(mwr_s),
    .io_select_n_selected_i(ios_s), .a18_selected_i(a18_s),
    .ser_div2_wr_i(dv_wr), .ser_div2_val_i(dv_val), .async_tx_ch0_tri_wr_i(tx_wr),
    .async_tx_ch0_tri_val_i(tx_val), .irq12_edge_req_i(edge_req), .mode_o(mode_o),
    .osc_disable_o(osc_o), .int_reset_o(irst_o), .periph_reset_o(prst_o),
    .ser_clk_div2_o(div2_o), .host_emul_en_o(host_o),
    .irq12_edge_en_o(edge_o), .core_pin_oe_o(core_o), .wait_oe_o(wait_o),
    .irq_zero_od_en_o(irq0_o), .data_oe_allow_o(data_o), .eclk_oe_o(eclk_o),
    .async_tx_ch0_oe_o(tx0_o), .async_tx_ch1_oe_o(tx1_o),
    .rts_ch0_oe_o(rts_o), .mem_strobe_force_hi_o(mstr_o),
    .sel_force_hi_o(sel_o), .io_select_oe_o(ios_o), .rdwr_oe_o(rdwr_o),
    .addr_oe_o(addr_o), .a18_oe_o(a18_o), .periph_out_oe_o(per_o));

  // 125 MHz core clock
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Reset with straps set; gap is cycles from periph to internal release
  task automatic do_reset(input logic [1:0] m);
    int i;
    mode_sel = m;
    rst_i = 1'b1;
    step(4);
    check("reset_hold", {prst_o, irst_o}, 2'h3);
    rst_i = 1'b0;
    i = 0;
    while (prst_o !== 1'b0 && i < 40) begin
      step(1);
      i++;
    end
    gap = 0;
    // Probe and test modes keep the core in reset; no wait there
    while (irst_o !== 1'b0 && gap < 40 && m < 2'h2) begin
      step(1);
      gap++;
    end
    if (i == 40 || gap == 40) begin
      check("reset_release_timeout", 32'h1, 32'h0);
      end_sim();
    end
  endtask

  // Pin enables per mode: core, wait, irq0, data, eclk, tx0, tx1, rts,
  // oscillator off, peripheral outputs
  function automatic logic [19:0] pins_exp(input logic [1:0] m);
    case (m)
      2'h0:    pins_exp = {11'h7FF, 9'h07D};
      2'h1:    pins_exp = {11'h000, 9'h1C3};
      default: pins_exp = {11'h000, 9'h002};
    endcase
  endfunction

  // Power-down group: strobes high, selects high, io sel, rd/wr, addr,
  // a18, host port, data
  function automatic logic [7:0] pd_vec();
    pd_vec = {mstr_o, sel_o, ios_o, rdwr_o, addr_o, a18_o, host_o, data_o};
  endfunction

  initial begin
    {rst_i, ce_i, pd, mrd_s, mwr_s, ios_s, a18_s} = 7'h6F;
    {dv_wr, dv_val, tx_wr, tx_val, edge_req, mode_sel} = 7'h04;
    // Every documented mode that the system may strap
    for (int m = 0; m < 3; m++) begin
      do_reset(m[1:0]);
      step(2);
      check("mode", mode_o, m);
      pv = {core_o, wait_o, irq0_o, data_o, eclk_o, tx0_o, tx1_o, rts_o,
            osc_o, per_o};
      pe = pins_exp(m[1:0]);
      check("pins", pv, pe);
      check("div2_reset", div2_o, 1'b0);
      check("oneshot", gap, (m == 0) ? EMPC_ONESHOT_CYC : 0);
      check("int_reset", irst_o, m == 2);
      check("clash", emu_drv && (a18_o || core_o != '0), 1'b0);
      if (m < 2) begin
        check("edge_en", edge_o, m == 0);
        check("host_en", host_o, 1'b1);
      end
    end
    // Second reset in mid-run back to normal; straps moved afterwards
    do_reset(2'h0);
    mode_sel = 2'h1;
    step(10);
    check("mode_held", mode_o, 2'h0);
    check("pd_idle", pd_vec(), 8'h3F);
    // Sleep or halt with every function selected
    pd = 1'b1;
    step(3);
    check("halt", pd_vec(), 8'hC0);
    check("tx0_no_float", tx0_o, 1'b1);
    tx_wr = 1'b1;
    tx_val = 1'b1;
    step(1);
    tx_wr = 1'b0;
    mrd_s = 1'b0;
    mwr_s = 1'b0;
    step(3);
    check("tx0_float", tx0_o, 1'b0);
    check("strobe_unsel", mstr_o, 1'b0);
    check("sel_high", sel_o, 1'b1);
    pd = 1'b0;
    step(3);
    check("tx0_awake", tx0_o, 1'b1);
    check("pd_off", host_o, 1'b1);
    dv_wr = 1'b1;
    dv_val = 1'b1;
    step(1);
    dv_wr = 1'b0;
    step(2);
    check("div2_set", div2_o, 1'b1);
    // Reset clears the divider and the tx0 float enable
    do_reset(2'h0);
    check("div2_cleared", div2_o, 1'b0);
    pd = 1'b1;
    step(3);
    check("tx0_cleared", tx0_o, 1'b1);
    end_sim();
  end
endmodule
